//--- hw/civ_consts.svh
// constants for the can interrupt code encoder
// Summary of operation
// - filter-hit field bits 12:8, filter number
// - fifo interrupt code equals fifo index
// - no pending interrupt reads 1000000
// - bus error reports code 1000001
// - wake-up reports code 1000010
// - receive overflow reports code 1000011
// - address error reports code 1000100
// - bandwidth error reports code 1000101
// - timestamp timer reports code 1000110
// - mode change reports code 1001111
// - invalid message reports code 1001000
// - only enabled sources change the code field; every accepted message loads the filter-hit field
// - unused bits read zero, writes ignored
`ifndef CIV_CONSTS_SVH
`define CIV_CONSTS_SVH
// ----------------------------------------
// register map
// ----------------------------------------
`define CIV_VEC_OFFSET     8'h00
`define CIV_STAT_OFFSET    8'h04
`define CIV_SRCEN_OFFSET   8'h08
`define CIV_IRQEN_OFFSET   8'h0c
`define CIV_IRQCLR_OFFSET  8'h10
// ----------------------------------------
// field positions and codes
// ----------------------------------------
`define CIV_HIT_LSB        8
`define CIV_CODE_NONE      7'h40
`define CIV_CODE_BUSERR    7'h41
`define CIV_CODE_WAKE      7'h42
`define CIV_CODE_RXOVF     7'h43
`define CIV_CODE_ADDRERR   7'h44
`define CIV_CODE_BWERR     7'h45
`define CIV_CODE_TSTMR     7'h46
`define CIV_CODE_MODE      7'h4f
`define CIV_CODE_INVMSG    7'h48
`define CIV_SRCEN_RESET    8'h00
`endif

//--- hw/civ_pkg.sv
// types of the can interrupt code encoder
package civ_pkg;
   typedef struct packed {
      logic [6:0]  code;
      logic [4:0]  hit;
      logic [1:0]  stat;
      logic [1:0]  irqEn;
      logic [7:0]  srcEn;
      logic [31:0] rdata;
      logic        irq;
   } civ_state_t;
endpackage

//--- hw/civ_encoder.sv
// can interrupt code encoder with register port
`timescale 1ns/1ns
`include "civ_consts.svh"
module civ_encoder #(
   parameter int NUM_FIFO = 32
) (
   input  wire logic          sys_clk,
   input  wire logic          rstn,
   input  wire logic [7:0]    regAddr,
   input  wire logic [31:0]   regWdata,
   input  wire logic          regWrite,
   input  wire logic          regRead,
   output logic      [31:0]   regRdata,
   output logic               irqOut,
   input  wire logic [31:0]   fifo_status_vector,
   input  wire logic [31:0]   fifoIntEnable,
   input  wire logic          bus_error_flag,
   input  wire logic          wakeup_flag,
   input  wire logic          receive_overflow_flag,
   input  wire logic          addrErrFlag,
   input  wire logic          bandwidthErrFlag,
   input  wire logic          timestamp_timer_flag,
   input  wire logic          mode_change_flag,
   input  wire logic          invalid_message_flag,
   input  wire logic          msgAccepted,
   input  wire logic [4:0]    acceptFilter
);
   import civ_pkg::*;

   initial begin
      if (NUM_FIFO < 1 || NUM_FIFO > 32) begin
         $error("NUM_FIFO must be 1 to 32");
      end
   end

   civ_state_t state_reg;
   civ_state_t state_next;
   logic [7:0]  modPend;
   logic [31:0] fifoPend;
   logic [6:0]  newCode;
   logic [31:0] vecWord;

   // ----------------------------------------
   // pending and enabled sources
   // ----------------------------------------
   // bit order equals priority order, lowest bit wins
   assign modPend = state_reg.srcEn & {invalid_message_flag, mode_change_flag,
      timestamp_timer_flag, bandwidthErrFlag, addrErrFlag, receive_overflow_flag,
      wakeup_flag, bus_error_flag};

   generate
      for (genvar i = 0; i < 32; i++) begin : g_fifo
         if (i < NUM_FIFO) begin : g_on
            assign fifoPend[i] = fifo_status_vector[i] & fifoIntEnable[i];
         end else begin : g_off
            assign fifoPend[i] = 1'b0;
         end
      end
   endgenerate

   // ----------------------------------------
   // priority encoder
   // ----------------------------------------
   // module events outrank fifos; errors must not starve behind traffic
   always_comb begin
      newCode = `CIV_CODE_NONE;
      for (int i = 31; i >= 0; i--) begin
         if (fifoPend[i]) begin
            newCode = 7'(i);
         end
      end
      if (modPend[7]) newCode = `CIV_CODE_INVMSG;
      if (modPend[6]) newCode = `CIV_CODE_MODE;
      if (modPend[5]) newCode = `CIV_CODE_TSTMR;
      if (modPend[4]) newCode = `CIV_CODE_BWERR;
      if (modPend[3]) newCode = `CIV_CODE_ADDRERR;
      if (modPend[2]) newCode = `CIV_CODE_RXOVF;
      if (modPend[1]) newCode = `CIV_CODE_WAKE;
      if (modPend[0]) newCode = `CIV_CODE_BUSERR;
   end

   assign vecWord = {19'h0, state_reg.hit, 1'b0, state_reg.code};

   // ----------------------------------------
   // state update
   // ----------------------------------------
   always_comb begin
      state_next = state_reg;
      state_next.code = newCode;
      if (msgAccepted) begin
         state_next.hit = acceptFilter;
      end
      if (regWrite && regAddr == `CIV_SRCEN_OFFSET) begin
         state_next.srcEn = regWdata[7:0];
      end
      if (regWrite && regAddr == `CIV_IRQEN_OFFSET) begin
         state_next.irqEn = regWdata[1:0];
      end
      if (regWrite && regAddr == `CIV_IRQCLR_OFFSET) begin
         state_next.stat = state_reg.stat & ~regWdata[1:0];
      end
      // set wins over a clear in the same cycle
      if (newCode != `CIV_CODE_NONE && state_reg.code == `CIV_CODE_NONE) begin
         state_next.stat[0] = 1'b1;
      end
      if (msgAccepted) begin
         state_next.stat[1] = 1'b1;
      end
      state_next.irq = |(state_next.stat & state_next.irqEn);
      state_next.rdata = 32'h0;
      if (regRead) begin
         unique case (regAddr)
            `CIV_VEC_OFFSET:   state_next.rdata = vecWord;
            `CIV_STAT_OFFSET:  state_next.rdata = {30'h0, state_reg.stat};
            `CIV_SRCEN_OFFSET: state_next.rdata = {24'h0, state_reg.srcEn};
            `CIV_IRQEN_OFFSET: state_next.rdata = {30'h0, state_reg.irqEn};
            default:           state_next.rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state_reg       <= '0;
         state_reg.code  <= `CIV_CODE_NONE;
         state_reg.srcEn <= `CIV_SRCEN_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   assign regRdata = state_reg.rdata;
   assign irqOut   = state_reg.irq;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   AST_NONE: assert property (@(posedge sys_clk) disable iff (!rstn)
      (modPend == 8'h0 && fifoPend == 32'h0) |=> state_reg.code == `CIV_CODE_NONE)
      else $error("idle code wrong");
   AST_BUSERR: assert property (@(posedge sys_clk) disable iff (!rstn)
      modPend[0] |=> state_reg.code == `CIV_CODE_BUSERR)
      else $error("bus error code wrong");
   AST_MODE: assert property (@(posedge sys_clk) disable iff (!rstn)
      (modPend[6:0] == 7'h40) |=> state_reg.code == `CIV_CODE_MODE)
      else $error("mode change code wrong");
   AST_FIFO: assert property (@(posedge sys_clk) disable iff (!rstn)
      (modPend == 8'h0 && fifoPend[0]) |=> state_reg.code == 7'h00)
      else $error("fifo code wrong");
   AST_RESV: assert property (@(posedge sys_clk) disable iff (!rstn)
      !(state_reg.code inside {[7'h20:7'h3f], [7'h49:7'h4e], [7'h50:7'h7f]}))
      else $error("reserved code produced");
   AST_MASKED: assert property (@(posedge sys_clk) disable iff (!rstn)
      (state_reg.srcEn == 8'h0 && fifoIntEnable == 32'h0) |=>
      state_reg.code == `CIV_CODE_NONE)
      else $error("disabled source reported");
   AST_HIT: assert property (@(posedge sys_clk) disable iff (!rstn)
      msgAccepted |=> state_reg.hit == $past(acceptFilter))
      else $error("filter hit not captured");
   AST_ZERO: assert property (@(posedge sys_clk) disable iff (!rstn)
      (regRead && regAddr == `CIV_VEC_OFFSET) |=>
      (regRdata[31:13] == 19'h0 && regRdata[7] == 1'b0))
      else $error("unused bits not zero");
   AST_RDVEC: assert property (@(posedge sys_clk) disable iff (!rstn)
      (regRead && regAddr == `CIV_VEC_OFFSET) |=>
      regRdata[12:8] == $past(state_reg.hit))
      else $error("filter field wrong");
   COV_FIFO: cover property (@(posedge sys_clk) disable iff (!rstn)
      state_reg.code == 7'h1f);
   COV_INV: cover property (@(posedge sys_clk) disable iff (!rstn)
      state_reg.code == `CIV_CODE_INVMSG);
   COV_IRQ: cover property (@(posedge sys_clk) disable iff (!rstn) irqOut);
endmodule

//--- sim/civ_encoder_test.sv
// self-checking bench of the can interrupt code encoder
`timescale 1ns/1ns
module civ_encoder_test;
   logic        sys_clk  = 1'b0;
   logic        rstn     = 1'b0;
   logic [7:0]  regAddr  = 8'h00;
   logic [31:0] regWdata = 32'h0;
   logic        regWrite = 1'b0;
   logic        regRead  = 1'b0;
   logic [31:0] regRdata;
   logic        irqOut;
   logic [31:0] fifoSt   = 32'h0;
   logic [31:0] fifoEn   = 32'h0;
   logic [7:0]  flg      = 8'h00;
   logic [7:0]  srcEn    = 8'h00;
   logic        msgAcc   = 1'b0;
   logic [4:0]  filt     = 5'h00;
   logic [4:0]  hitM     = 5'h00;
   logic [31:0] rv;
   logic [6:0]  codes [8] = '{7'h41, 7'h42, 7'h43, 7'h44, 7'h45, 7'h46, 7'h4f, 7'h48};
   int          err_count = 0;
   int          tests_run = 0;

   always #4 sys_clk = ~sys_clk;

   civ_encoder i_civ_encoder (.sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr),
      .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
      .irqOut(irqOut), .fifo_status_vector(fifoSt), .fifoIntEnable(fifoEn),
      .bus_error_flag(flg[0]), .wakeup_flag(flg[1]), .receive_overflow_flag(flg[2]),
      .addrErrFlag(flg[3]), .bandwidthErrFlag(flg[4]), .timestamp_timer_flag(flg[5]),
      .mode_change_flag(flg[6]), .invalid_message_flag(flg[7]), .msgAccepted(msgAcc),
      .acceptFilter(filt));

   // ----------------------------------------
   // model and bus tasks
   // ----------------------------------------
   // walking upward from the lowest priority lets the winner overwrite
   function automatic logic [31:0] expVec();
      logic [6:0] c;
      c = 7'h40;
      for (int j = 31; j >= 0; j--) if (fifoSt[j] && fifoEn[j]) c = 7'(j);
      for (int i = 7; i >= 0; i--) if (flg[i] && srcEn[i]) c = codes[i];
      return {19'h0, hitM, 1'b0, c};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      regAddr  <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge sys_clk);
      regWrite <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge sys_clk);
      regRead <= 1'b0;
      // data stand in the cycle after the read edge; sample before the next update
      @(posedge sys_clk);
      d = regRdata;
   endtask
   task automatic test_done();
      if (err_count == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      #200000 err_count++;
      test_done();
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(32'heb7902da));
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      rd(8'h00, rv);
      chk(rv, 32'h40);
      wr(8'h00, 32'hffff_ffff);
      rd(8'h00, rv);
      chk(rv, 32'h40);
      rd(8'h14, rv);
      chk(rv, 32'h0);
      srcEn = 8'hff;
      wr(8'h08, 32'hff);
      for (int i = 0; i < 8; i++) begin
         flg <= 8'h01 << i;
         rd(8'h00, rv);
         chk(rv, expVec());
      end
      flg    <= 8'h00;
      fifoSt <= 32'hffff_ffff;
      fifoEn <= 32'h8000_0000;
      rd(8'h00, rv);
      chk(rv, expVec());
      for (int n = 0; n < 40; n++) begin
         srcEn = 8'($urandom);
         wr(8'h08, {24'h0, srcEn});
         flg    <= 8'($urandom) & 8'($urandom);
         fifoSt <= $urandom & $urandom;
         fifoEn <= $urandom;
         rd(8'h00, rv);
         chk(rv, expVec());
      end
      flg    <= 8'h00;
      fifoSt <= 32'h0;
      wr(8'h10, 32'h3);
      wr(8'h0c, 32'h2);
      filt   <= 5'h1f;
      msgAcc <= 1'b1;
      @(posedge sys_clk);
      msgAcc <= 1'b0;
      hitM = 5'h1f;
      repeat (2) @(posedge sys_clk);
      chk({31'h0, irqOut}, 32'h1);
      rd(8'h00, rv);
      chk(rv, expVec());
      rd(8'h04, rv);
      chk(rv, 32'h2);
      wr(8'h0c, 32'h0);
      @(posedge sys_clk);
      chk({31'h0, irqOut}, 32'h0);
      wr(8'h0c, 32'h2);
      wr(8'h10, 32'h2);
      @(posedge sys_clk);
      chk({31'h0, irqOut}, 32'h0);
      rd(8'h04, rv);
      chk(rv, 32'h0);
      test_done();
   end
endmodule
